// *** design/rdec_pkg.sv ***
// shared constants and types for the rs485 driver-enable controller
package rdec_pkg;
    // clock and line timing
    localparam int CLK_HZ = 25_000_000;
    localparam int MIN_BAUD_BPS = 1200;
    localparam int MAX_BAUD_BPS = 115200;
    localparam int FRAME_BITS = 10;
    // longest bit time, rounded down, used before a rate has been measured
    localparam int SLOW_BIT_CYC = CLK_HZ / MIN_BAUD_BPS;
    // shortest low pulse taken as a real bit: half a bit at the top rate
    localparam int MIN_PULSE_CYC = CLK_HZ / MAX_BAUD_BPS / 2;
    localparam int CNT_W = 16;
    localparam int BOOT_WAIT_CYC = 3;

    // register map, byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] BITTIME_OFS = 8'h08;
    // ctrl fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_REBAUD_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    // status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_SUPP_BIT = 2;
    localparam int ST_DE_BIT = 3;
    localparam int ST_VALID_BIT = 4;
    localparam int ST_LATCHED_BIT = 5;

    // mode-select switch code, in switch order
    typedef enum logic [1:0] {MODE_ALWAYS, MODE_AUTO, MODE_RTS, MODE_DATA} rdec_mode_t;
    typedef enum logic {FR_IDLE, FR_BUSY} rdec_frame_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } rdec_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rdec_apb_rsp_t;

    typedef struct packed {
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] bit_cyc;
        logic valid;
        logic prev;
    } rdec_baud_st_t;
endpackage

// *** design/rdec_autobaud.sv ***
// bit-time estimator: shortest valid low pulse seen on transmit data
`timescale 1ns/1ps
`default_nettype none
module rdec_autobaud (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic txd, // synchronised transmit data
    input wire logic clear, // forget the measured rate
    output logic [rdec_pkg::CNT_W-1:0] bit_cyc, // measured bit time in cycles
    output logic valid // a rate has been measured
);
    import rdec_pkg::*;

    rdec_baud_st_t s_q, s_d;

    // a lone start bit or a single zero gives one bit time; the minimum wins
    always_comb begin
        s_d = s_q;
        s_d.prev = txd;
        // clear first, so a pulse that ends in the same cycle still counts
        if (clear) begin
            s_d.valid = 1'b0;
            s_d.bit_cyc = '0;
        end
        if (!txd) begin
            if (s_q.low_cnt != {CNT_W{1'b1}}) begin
                s_d.low_cnt = s_q.low_cnt + 1'b1;
            end
        end else begin
            s_d.low_cnt = '0;
            // pulses shorter than half a bit at top rate are treated as noise
            if (!s_q.prev && s_q.low_cnt >= CNT_W'(MIN_PULSE_CYC) &&
                (!s_d.valid || s_q.low_cnt < s_q.bit_cyc)) begin
                s_d.bit_cyc = s_q.low_cnt;
                s_d.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{low_cnt: '0, bit_cyc: '0, valid: 1'b0, prev: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign bit_cyc = s_q.bit_cyc;
    assign valid = s_q.valid;
endmodule // rdec_autobaud
`default_nettype wire

// *** design/rdec_driver_ctrl.sv ***
// rs485 driver-enable and receive-echo control with apb status port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - mode switch latched once after reset
// - data mode: low data drives line
// - data mode: high data tri-states driver
// - rts mode: request-to-send gates driver
// - auto mode: measure baud, derive enable
// - always mode: driver and led on while enabled
// - echo allowed: line receive returned
// - switch position six suppresses echo
// - transmit data sampled every cycle, first
// - auto release within allowed bit times
module rdec_driver_ctrl #(
    parameter int SLOW_BIT_CYC_P = rdec_pkg::SLOW_BIT_CYC // bit time before a rate is known
) (
    input wire logic pclk, // system clock, 25 MHz
    input wire logic presetn, // async reset, active low
    input wire rdec_pkg::rdec_apb_req_t apb_req, // apb request signals
    output rdec_pkg::rdec_apb_rsp_t apb_rsp, // apb answer, registered
    input wire logic host_txd, // transmit data from host uart
    input wire logic host_rts, // request-to-send from host, high asserted
    output logic host_rxd, // receive data to host uart
    input wire logic line_rxd, // line receiver output
    output logic line_txd, // data into line driver
    output logic line_de, // line driver enable, high drives
    output logic en_led, // transmit-enable indicator
    input wire logic [1:0] mode_select_switch, // communication mode straps
    input wire logic line_config_switch_6 // on suppresses echo
);
    import rdec_pkg::*;

    // block state, apart from the rate estimator in u_baud, in one record, registered once below
    typedef struct packed {
        logic tx_s1;
        logic tx_s2;
        logic tx_prev;
        logic rts_s1;
        logic rts_s2;
        logic rx_s1;
        logic rx_s2;
        logic [1:0] msw_s1;
        logic [1:0] msw_s2;
        logic lsw_s1;
        logic lsw_s2;
        logic [1:0] boot_cnt;
        logic latched;
        rdec_mode_t mode;
        rdec_frame_t frame;
        logic [3:0] bit_cnt;
        logic [CNT_W-1:0] cyc_cnt;
        logic ctrl_en;
        logic rebaud;
        rdec_apb_rsp_t rsp;
        logic line_txd;
        logic line_de;
        logic host_rxd;
        logic en_led;
    } st_t;

    st_t s_q, s_d;
    logic [CNT_W-1:0] meas_cyc;
    logic meas_valid;
    logic [CNT_W-1:0] bit_len;
    logic fall;
    logic de_next;

    // word index match on the register map
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    rdec_autobaud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .txd(s_q.tx_s2),
        .clear(s_q.rebaud),
        .bit_cyc(meas_cyc),
        .valid(meas_valid)
    );

    // slow default keeps the driver on long enough until a rate is known
    assign bit_len = meas_valid ? meas_cyc : CNT_W'(SLOW_BIT_CYC_P);
    assign fall = s_q.tx_prev && !s_q.tx_s2;

    always_comb begin
        s_d = s_q;
        s_d.tx_s1 = host_txd;
        s_d.tx_s2 = s_q.tx_s1;
        s_d.tx_prev = s_q.tx_s2;
        s_d.rts_s1 = host_rts;
        s_d.rts_s2 = s_q.rts_s1;
        s_d.rx_s1 = line_rxd;
        s_d.rx_s2 = s_q.rx_s1;
        s_d.msw_s1 = mode_select_switch;
        s_d.msw_s2 = s_q.msw_s1;
        s_d.lsw_s1 = line_config_switch_6;
        s_d.lsw_s2 = s_q.lsw_s1;
        // rebaud is a one-cycle pulse, low unless a write raises it
        s_d.rebaud = 1'b0;

        // one-time strap capture
        // the strap is never read again, so a new mode needs a fresh reset
        if (!s_q.latched) begin
            if (s_q.boot_cnt == 2'(BOOT_WAIT_CYC - 1)) begin
                s_d.latched = 1'b1;
                s_d.mode = rdec_mode_t'(s_q.msw_s2);
            end else begin
                s_d.boot_cnt = s_q.boot_cnt + 1'b1;
            end
        end

        // frame timer, released at end of stop bit
        // a falling edge inside a frame is data, not a new start
        case (s_q.frame)
            FR_IDLE: begin
                if (fall && s_q.mode == MODE_AUTO && s_q.latched) begin
                    s_d.frame = FR_BUSY;
                    s_d.bit_cnt = '0;
                    s_d.cyc_cnt = '0;
                end
            end
            FR_BUSY: begin
                if (s_q.cyc_cnt >= bit_len - 1'b1) begin
                    s_d.cyc_cnt = '0;
                    if (s_q.bit_cnt == 4'(FRAME_BITS - 1)) begin
                        s_d.frame = FR_IDLE;
                    end else begin
                        s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                    end
                end else begin
                    s_d.cyc_cnt = s_q.cyc_cnt + 1'b1;
                end
            end
            default: begin
                s_d.frame = FR_IDLE;
            end
        endcase

        // driver enable source chosen by the latched mode
        // frame state taken from s_d so auto mode drives from the start edge on
        // clearing the enable bit overrides every mode, always-on included
        de_next = 1'b0;
        if (s_q.latched && s_q.ctrl_en) begin
            case (s_q.mode)
                MODE_ALWAYS: de_next = 1'b1;
                MODE_AUTO: de_next = (s_d.frame == FR_BUSY);
                MODE_RTS: de_next = s_q.rts_s2;
                MODE_DATA: de_next = !s_q.tx_s2;
                default: de_next = 1'b0;
            endcase
        end
        s_d.line_de = de_next;
        s_d.en_led = de_next;
        s_d.line_txd = s_q.tx_s2;

        if (s_q.lsw_s2 && de_next) begin
            s_d.host_rxd = 1'b1;
        end else begin
            s_d.host_rxd = s_q.rx_s2;
        end

        // apb: read data latched in setup, answered in first access cycle
        // zero wait states; status shows the state of the setup edge
        // limitation: a change during the access cycle is seen on the next read
        s_d.rsp.pready = apb_req.psel && !apb_req.penable;
        s_d.rsp.pslverr = 1'b0;
        if (apb_req.psel && !apb_req.penable) begin
            s_d.rsp.prdata = '0;
            if (hit(apb_req.paddr, CTRL_OFS)) begin
                s_d.rsp.prdata[CTRL_EN_BIT] = s_q.ctrl_en;
            end else if (hit(apb_req.paddr, STATUS_OFS)) begin
                s_d.rsp.prdata[ST_MODE_LSB +: 2] = s_q.mode;
                s_d.rsp.prdata[ST_SUPP_BIT] = s_q.lsw_s2;
                s_d.rsp.prdata[ST_DE_BIT] = s_q.line_de;
                s_d.rsp.prdata[ST_VALID_BIT] = meas_valid;
                s_d.rsp.prdata[ST_LATCHED_BIT] = s_q.latched;
            end else if (hit(apb_req.paddr, BITTIME_OFS)) begin
                s_d.rsp.prdata[CNT_W-1:0] = bit_len;
            end else begin
                // unmapped: error flagged with the answer
                s_d.rsp.pslverr = 1'b1;
            end
        end
        // write takes effect on the completing access edge
        if (apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite &&
            hit(apb_req.paddr, CTRL_OFS)) begin
            s_d.ctrl_en = apb_req.pwdata[CTRL_EN_BIT];
            s_d.rebaud = apb_req.pwdata[CTRL_REBAUD_BIT];
        end
    end

    // reset leaves the driver off and the host line at mark
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{tx_s1: 1'b1, tx_s2: 1'b1, tx_prev: 1'b1, rts_s1: 1'b0, rts_s2: 1'b0,
                     rx_s1: 1'b1, rx_s2: 1'b1, msw_s1: 2'h0, msw_s2: 2'h0, lsw_s1: 1'b0,
                     lsw_s2: 1'b0, boot_cnt: 2'h0, latched: 1'b0, mode: MODE_ALWAYS,
                     frame: FR_IDLE, bit_cnt: 4'h0, cyc_cnt: '0, ctrl_en: CTRL_EN_RST,
                     rebaud: 1'b0, rsp: '0, line_txd: 1'b1, line_de: 1'b0, host_rxd: 1'b1,
                     en_led: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // every output comes straight from the registered record
    assign apb_rsp = s_q.rsp;
    assign line_txd = s_q.line_txd;
    assign line_de = s_q.line_de;
    assign host_rxd = s_q.host_rxd;
    assign en_led = s_q.en_led;
endmodule // rdec_driver_ctrl
`default_nettype wire

// *** test/rdec_checker_assertions.sv ***
// port checks for the driver-enable controller
`timescale 1ns/1ps
`default_nettype none
module rdec_checker #(
    parameter int SLOW_BIT_CYC_P = 20833 // kept in step with dut
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire rdec_pkg::rdec_apb_req_t apb_req, // apb in
    input wire rdec_pkg::rdec_apb_rsp_t apb_rsp, // apb out
    input wire logic host_txd, // host data
    input wire logic host_rts, // host rts
    input wire logic host_rxd, // to host
    input wire logic line_rxd, // from line
    input wire logic line_txd, // to line
    input wire logic line_de, // enable
    input wire logic en_led, // led
    input wire logic [1:0] mode_select_switch, // straps
    input wire logic line_config_switch_6 // echo off
);
    import rdec_pkg::*;
    logic [2:0] up_q; // edges since release
    logic [1:0] mode_q; // strap as latched
    logic run; // outputs settled
    assign run = up_q == 3'h7;
    // straps only count at release; later changes must not matter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q <= 3'h0;
            mode_q <= 2'h0;
        end else begin
            if (!run)
                up_q <= up_q + 3'h1;
            if (up_q == 3'h0)
                mode_q <= mode_select_switch;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    led_mirror_a: assert property (en_led == line_de) else $error("led differs");
    always_on_a: assert property (run && mode_q == MODE_ALWAYS |-> line_de) else $error("not driving");
    data_high_a: assert property ((run && mode_q == MODE_DATA && host_txd)[*4] |-> !line_de) else $error("drives");
    rts_gate_a: assert property ((run && mode_q == MODE_RTS && $stable(host_rts))[*4] |-> line_de == host_rts)
        else $error("rts not followed");
    txd_follow_a: assert property ((run && $stable(host_txd))[*4] |-> line_txd == host_txd) else $error("txd");
    mark_hold_a: assert property ((run && line_config_switch_6)[*4] ##0 (line_de && $past(line_de)) |-> host_rxd)
        else $error("echo not held");
    echo_pass_a: assert property ((run && !line_config_switch_6 && !line_rxd)[*4] |-> !host_rxd) else $error("echo");
    zero_wait_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("apb wait");
    unmapped_a: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr == 8'h0c |=> apb_rsp.pslverr)
        else $error("no error");
    cover property (line_de && mode_q == MODE_AUTO);
    cover property (apb_rsp.pslverr);
    cover property (line_config_switch_6 && line_de);
endmodule // rdec_checker
`default_nettype wire

// *** test/rdec_host_uart.sv ***
// host uart model: one start, eight data, one stop bit per character
`timescale 1ns/1ps
`default_nettype none
module rdec_host_uart (
    input wire logic pclk, // clock
    input wire logic go, // send one character
    input wire logic brk, // hold line low
    input wire logic [7:0] data, // character
    output logic txd, // idle high
    output logic busy // frame running
);
    localparam int BIT_CYC = 250; // 100 kbps
    logic [9:0] fr; // frame bits
    // frames run back to back only when asked; idle is mark unless brk holds the line low
    initial begin
        txd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            // idle follows the break request; a frame owns the pin while it runs
            if (!go) begin
                txd <= ~brk;
            end
            if (go) begin
                busy <= 1'b1;
                fr = {1'b1, data, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    txd <= fr[i];
                    repeat (BIT_CYC) @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // rdec_host_uart
`default_nettype wire

// *** test/test_rdec_driver_ctrl.sv ***
// self-checking bench for the driver-enable controller
`timescale 1ns/1ps
`default_nettype none
module test_rdec_driver_ctrl;
    import rdec_pkg::*;
    logic pclk, presetn, txd, rts, rxd, sw6, go, brk, busy, hrxd, ltxd, de, led, se;
    logic [1:0] msw;
    logic [31:0] rd;
    logic [7:0] r;
    rdec_apb_req_t req;
    rdec_apb_rsp_t rsp;
    int failures = 0;
    int total_checks = 0;
    // mode, brk, rts, sw6, rxd, expected enable, expected rxd
    logic [7:0] rows [6] = '{8'h02, 8'h0b, 8'he2, 8'hc8, 8'h9b, 8'h85};
    rdec_driver_ctrl #(.SLOW_BIT_CYC_P(1000)) dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .host_txd(txd), .host_rts(rts), .host_rxd(hrxd), .line_rxd(rxd), .line_txd(ltxd), .line_de(de),
        .en_led(led), .mode_select_switch(msw), .line_config_switch_6(sw6));
    rdec_host_uart host (.pclk(pclk), .go(go), .brk(brk), .data(8'h55), .txd(txd), .busy(busy));
    task automatic finish_test;
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reboot;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // apb transfer; pready sampled at the rising edge, answer taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            finish_test();
        end
        rd = rsp.prdata;
        se = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        int n;
        {presetn, rts, rxd, sw6, go, brk, msw} <= '0;
        req <= '0;
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            @(posedge pclk);
            {msw, brk, rts, sw6, rxd} <= r[7:2];
            reboot();
            check(de, r[1]);
            check(led, r[1]);
            check(hrxd, r[0]);
        end
        @(posedge pclk);
        {msw, brk, rts, sw6, rxd} <= {MODE_AUTO, 4'h1};
        reboot();
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        check(rd[0], CTRL_EN_RST);
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((de || busy) && n < 30000);
        check(n < 30000, 1'b1);
        if (n >= 30000) begin
            finish_test();
        end
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        wait_cyc(2375);
        check(de, 1'b1);
        wait_cyc(1125); // four bit times past the end of the stop bit
        check(de, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        check(rd[5:0], 6'h31);
        apb(1'b0, BITTIME_OFS, 32'h0000_0000);
        check(rd[15:0] >= 248 && rd[15:0] <= 252, 1'b1);
        // rebaud forgets the rate, so the slow default is back in use
        apb(1'b1, CTRL_OFS, 32'h0000_0003);
        wait_cyc(2);
        apb(1'b0, BITTIME_OFS, 32'h0000_0000);
        check(rd[15:0], 16'h03e8);
        apb(1'b1, 8'h0c, 32'h0000_0001);
        check(se, 1'b1);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check(se, 1'b1);
        check(rd, 32'h0000_0000);
        @(posedge pclk);
        msw <= MODE_DATA;
        reboot();
        @(posedge pclk);
        msw <= MODE_ALWAYS;
        wait_cyc(10);
        check(de, 1'b0);
        @(posedge pclk);
        brk <= 1'b1;
        wait_cyc(6);
        check({de, ltxd}, 2'h2);
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        wait_cyc(6);
        check(de, 1'b0);
        finish_test();
    end
endmodule // test_rdec_driver_ctrl
bind rdec_driver_ctrl rdec_checker #(.SLOW_BIT_CYC_P(SLOW_BIT_CYC_P)) chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .host_txd(host_txd), .host_rts(host_rts), .host_rxd(host_rxd),
    .line_rxd(line_rxd), .line_txd(line_txd), .line_de(line_de), .en_led(en_led),
    .mode_select_switch(mode_select_switch), .line_config_switch_6(line_config_switch_6));
`default_nettype wire
